// ==== core/wccb_lane.sv ====
module wccb_lane
   import wccb_pkg::*;
(
   // stored configuration for this input
   input  wire logic [wccb_pkg::CODE_W-1:0] code,
   input  wire logic                        sink_sel,
   input  wire logic                        off_sink,
   input  wire logic                        off_source,
   // operating state
   input  wire logic                        continuous_mode,
   input  wire logic                        switch_closed,
   // resulting current
   output wccb_pkg::wccb_level_t            level
);

   wccb_level_t base;
   logic        scale_off;

   always_comb begin
      base = wccb_decode(code);
      scale_off = sink_sel ? off_sink : off_source;
      level = base;
      // only the two high settings fall back, and only when closed
      if (continuous_mode && switch_closed && !scale_off &&
          (base == WCCB_10MA || base == WCCB_15MA)) begin
         level = WCCB_2MA;
      end
   end

endmodule

// ==== core/wccb_pkg.sv ====
package wccb_pkg;

   // register access port and input bank geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam int NUM_INPUTS = 24;
   localparam int NUM_DIR = 10;
   localparam int CODE_W = 3;
   localparam int NUM_FIELDS = 15;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_DIR_SEL = 6'h1c;
   localparam logic [ADDR_W-1:0] ADDR_WET_A = 6'h1d;
   localparam logic [ADDR_W-1:0] ADDR_WET_B = 6'h1e;

   // reset values
   localparam logic [DATA_W-1:0] RST_DIR_SEL = 24'h00_0000;
   localparam logic [DATA_W-1:0] RST_WET_A = 24'h00_0000;
   localparam logic [DATA_W-1:0] RST_WET_B = 24'h00_0000;

   // writable bit masks; everything else reads zero
   localparam logic [DATA_W-1:0] MASK_DIR_SEL = 24'h00_03ff;
   localparam logic [DATA_W-1:0] MASK_WET_A = 24'hff_ffff;
   localparam logic [DATA_W-1:0] MASK_WET_B = 24'h7f_ffff;

   // field positions in the second wetting-level register
   localparam int POS_OFF_SINK = 22;
   localparam int POS_OFF_SOURCE = 21;
   localparam int WIDTH_B_FIELDS = 21;

   typedef enum logic [CODE_W-1:0] {
      WCCB_OFF = 3'h0,
      WCCB_1MA = 3'h1,
      WCCB_2MA = 3'h2,
      WCCB_5MA = 3'h3,
      WCCB_10MA = 3'h4,
      WCCB_15MA = 3'h5
   } wccb_level_t;

   // codes 5..7 all collapse onto the top current
   function automatic wccb_level_t wccb_decode(input logic [CODE_W-1:0] code);
      wccb_level_t lvl;
      unique case (code)
         3'h0: lvl = WCCB_OFF;
         3'h1: lvl = WCCB_1MA;
         3'h2: lvl = WCCB_2MA;
         3'h3: lvl = WCCB_5MA;
         3'h4: lvl = WCCB_10MA;
         default: lvl = WCCB_15MA;
      endcase
      return lvl;
   endfunction

   // which 3-bit field (0..14) drives an input; pairs share one field
   function automatic logic [3:0] wccb_field_idx(input int idx);
      logic [3:0] f;
      unique case (idx)
         0, 1: f = 4'h0;
         2, 3: f = 4'h1;
         4: f = 4'h2;
         5: f = 4'h3;
         6, 7: f = 4'h4;
         8, 9: f = 4'h5;
         10: f = 4'h6;
         11: f = 4'h7;
         12, 13: f = 4'h8;
         14, 15: f = 4'h9;
         16, 17: f = 4'ha;
         18, 19: f = 4'hb;
         20, 21: f = 4'hc;
         22: f = 4'hd;
         default: f = 4'he;
      endcase
      return f;
   endfunction

endpackage

// ==== core/wccb_top.sv ====
// Functional notes
// - direction bits 9..0: zero sources current, one sinks current, per input
// - direction register bits 23..10 are read-only and read zero
// - codes 0..4 give off,1,2,5,10 mA; codes 5..7 give 15 mA
// - first wetting register at 0x1D, resets zero, holds inputs 0..11 fields
// - a paired field gives both inputs of the pair the same code; auto-scaling still acts on each input separately
// - second wetting register at 0x1E: reserved, two scale-off bits, inputs 12..23
// - direction register at 0x1C; all three reset to zero
// - scale-off clear: 10/15 mA drops to 2 mA on closure in continuous mode
module wccb_top
   import wccb_pkg::*;
(
   // clock and reset
   input  wire logic                                  sys_clk,
   input  wire logic                                  reset_n,
   // register access from the serial frame decoder
   input  wire logic                                  reg_wr_en,
   input  wire logic                                  reg_rd_en,
   input  wire logic [wccb_pkg::ADDR_W-1:0]           reg_addr,
   input  wire logic [wccb_pkg::DATA_W-1:0]           reg_wdata,
   output logic      [wccb_pkg::DATA_W-1:0]           reg_rdata,
   output logic                                       reg_rd_valid,
   // switch side status
   input  wire logic                                  continuous_mode,
   input  wire logic [wccb_pkg::NUM_INPUTS-1:0]       switch_closed,
   // configuration to the current generators
   output logic      [wccb_pkg::NUM_DIR-1:0]          input_sink_sel,
   output logic      [wccb_pkg::NUM_INPUTS*3-1:0]     wet_level,
   output logic                                       autoscale_off_sink,
   output logic                                       autoscale_off_source
);

   typedef struct packed {
      logic [NUM_DIR-1:0]          sink_sel;
      logic [DATA_W-1:0]           cfg_a;
      logic [WIDTH_B_FIELDS-1:0]   cfg_b;
      logic                        off_sink;
      logic                        off_source;
      logic [DATA_W-1:0]           rdata;
      logic                        rd_valid;
      logic [NUM_INPUTS*3-1:0]     level;
   } wccb_state_t;

   wccb_state_t st_r;
   wccb_state_t st_nxt;
   logic [NUM_INPUTS*3-1:0] lane_level;
   logic [NUM_FIELDS*3-1:0] fields;

   assign fields = {st_r.cfg_b, st_r.cfg_a};

   function automatic logic [CODE_W-1:0] field_code(input logic [NUM_FIELDS*3-1:0] f,
                                                    input int idx);
      return f[3*wccb_field_idx(idx) +: CODE_W];
   endfunction

   function automatic logic [DATA_W-1:0] reg_image(input wccb_state_t s,
                                                  input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] v;
      v = '0;
      unique case (a)
         ADDR_DIR_SEL: v = {{(DATA_W-NUM_DIR){1'b0}}, s.sink_sel};
         ADDR_WET_A: v = s.cfg_a;
         ADDR_WET_B: v = {1'b0, s.off_sink, s.off_source, s.cfg_b};
         default: v = '0;
      endcase
      return v;
   endfunction

   for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_lane
      logic sink;
      if (g < NUM_DIR) begin : g_dir
         assign sink = st_r.sink_sel[g];
      end else begin : g_fixed
         assign sink = 1'b0;
      end
      // pair members read the same field index
      wccb_lane u_lane (
         .code            (field_code(fields, g)),
         .sink_sel        (sink),
         .off_sink        (st_r.off_sink),
         .off_source      (st_r.off_source),
         .continuous_mode (continuous_mode),
         .switch_closed   (switch_closed[g]),
         .level           (lane_level[3*g +: 3])
      );
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_valid = reg_rd_en;
      // read returns the contents before a same-cycle write
      st_nxt.rdata = reg_rd_en ? reg_image(st_r, reg_addr) : '0;
      st_nxt.level = lane_level;
      if (reg_wr_en) begin
         unique case (reg_addr)
            ADDR_DIR_SEL: begin
               st_nxt.sink_sel = reg_wdata[NUM_DIR-1:0];
            end
            ADDR_WET_A: begin
               st_nxt.cfg_a = reg_wdata & MASK_WET_A;
            end
            ADDR_WET_B: begin
               st_nxt.cfg_b = reg_wdata[WIDTH_B_FIELDS-1:0];
               st_nxt.off_sink = reg_wdata[POS_OFF_SINK];
               st_nxt.off_source = reg_wdata[POS_OFF_SOURCE];
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r.sink_sel <= RST_DIR_SEL[NUM_DIR-1:0];
         st_r.cfg_a <= RST_WET_A;
         st_r.cfg_b <= RST_WET_B[WIDTH_B_FIELDS-1:0];
         st_r.off_sink <= RST_WET_B[POS_OFF_SINK];
         st_r.off_source <= RST_WET_B[POS_OFF_SOURCE];
         st_r.rdata <= '0;
         st_r.rd_valid <= 1'b0;
         st_r.level <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign reg_rd_valid = st_r.rd_valid;
   assign input_sink_sel = st_r.sink_sel;
   assign wet_level = st_r.level;
   assign autoscale_off_sink = st_r.off_sink;
   assign autoscale_off_source = st_r.off_source;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   property p_sink_bits;
      reg_wr_en && reg_addr == ADDR_DIR_SEL |=> input_sink_sel == $past(reg_wdata[9:0]);
   endproperty
   a_sink_bits: assert property (p_sink_bits)
      else $error("direction bits do not follow write");

   property p_dir_reserved;
      reg_rd_en && reg_addr == ADDR_DIR_SEL |=> reg_rd_valid && reg_rdata[23:10] == '0;
   endproperty
   a_dir_reserved: assert property (p_dir_reserved)
      else $error("direction reserved bits read nonzero");

   property p_decode;
      !continuous_mode |=> wccb_level_t'(wet_level[2:0]) == wccb_decode($past(st_r.cfg_a[2:0]));
   endproperty
   a_decode: assert property (p_decode)
      else $error("wetting code decoded wrongly");

   property p_wet_a_back;
      reg_wr_en && reg_addr == ADDR_WET_A ##1 reg_rd_en && reg_addr == ADDR_WET_A
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_wet_a_back: assert property (p_wet_a_back)
      else $error("first wetting register readback mismatch");

   // the mates may still differ legally when their directions differ and one scales down
   property p_pair;
      $past(switch_closed[9]) == $past(switch_closed[8])
         && $past(input_sink_sel[9]) == $past(input_sink_sel[8])
         |-> wet_level[29:27] == wet_level[26:24];
   endproperty
   a_pair: assert property (p_pair)
      else $error("paired inputs 8 and 9 differ");

   property p_wet_b_reserved;
      reg_rd_en && reg_addr == ADDR_WET_B |=> reg_rdata[23] == 1'b0
         && reg_rdata[22] == $past(autoscale_off_sink);
   endproperty
   a_wet_b_reserved: assert property (p_wet_b_reserved)
      else $error("second wetting register reads wrongly");

   property p_reset_zero;
      $rose(reset_n) |-> input_sink_sel == '0 && wet_level == '0 && !autoscale_off_sink
         && !autoscale_off_source;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("configuration not zero after reset");

   property p_autoscale;
      continuous_mode && switch_closed[10] && !autoscale_off_source
         && st_r.cfg_a[20:18] == 3'h4 |=> wet_level[32:30] == WCCB_2MA;
   endproperty
   a_autoscale: assert property (p_autoscale)
      else $error("auto-scaling did not reduce to 2 mA");

   property p_reserved_write;
      reg_wr_en && reg_addr == ADDR_DIR_SEL ##1 reg_rd_en && reg_addr == ADDR_DIR_SEL
         |=> reg_rdata[23:10] == '0 && reg_rdata[9:0] == $past(reg_wdata[9:0], 2);
   endproperty
   a_reserved_write: assert property (p_reserved_write)
      else $error("reserved direction bits were stored");

endmodule

// ==== tb/wccb_host.sv ====
module wccb_host
   import wccb_pkg::*;
(
   // clock
   input  wire logic                        sys_clk,
   // answers from the bank
   input  wire logic [wccb_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                        reg_rd_valid,
   // requests to the bank
   output logic                             reg_wr_en,
   output logic                             reg_rd_en,
   output logic      [wccb_pkg::ADDR_W-1:0] reg_addr,
   output logic      [wccb_pkg::DATA_W-1:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 24'h00_0000;
   end
   // released lines show inverted junk so stale values cannot pass
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // write then read back on the very next edge; address held across both
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic v);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b1;
      reg_wdata <= ~d;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      q = reg_rdata;
      v = reg_rd_valid;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
      @(posedge sys_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
      v = reg_rd_valid;
   endtask
endmodule

// ==== tb/wccb_top_tb.sv ====
module wccb_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wccb_pkg::*;
   logic                    sys_clk = 1'b0;
   logic                    reset_n = 1'b0;
   logic                    continuous_mode = 1'b0;
   logic [NUM_INPUTS-1:0]   switch_closed = 24'h00_0000;
   logic                    reg_wr_en, reg_rd_en, reg_rd_valid;
   logic [ADDR_W-1:0]       reg_addr;
   logic [DATA_W-1:0]       reg_wdata, reg_rdata;
   logic [NUM_DIR-1:0]      input_sink_sel;
   logic [NUM_INPUTS*3-1:0] wet_level;
   logic                    autoscale_off_sink, autoscale_off_source;
   logic [DATA_W-1:0]       dir_s = 24'h00_0000, a_s = 24'h00_0000, b_s = 24'h00_0000;
   int                      fails = 0, comparisons = 0;
   // field index per input; pairs share one field
   localparam int FLD [24] = '{0,0,1,1,2,3,4,4,5,5,6,7,8,8,9,9,10,10,11,11,12,12,13,14};
   always #5 sys_clk = ~sys_clk;
   wccb_host u_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   wccb_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .continuous_mode(continuous_mode),
      .switch_closed(switch_closed), .input_sink_sel(input_sink_sel), .wet_level(wet_level),
      .autoscale_off_sink(autoscale_off_sink), .autoscale_off_source(autoscale_off_source));
   function automatic logic [71:0] exp_lv();
      logic [71:0] r;
      logic [2:0]  c;
      logic [2:0]  l;
      logic        snk;
      r = '0;
      for (int i = 0; i < 24; i++) begin
         c = (FLD[i] < 8) ? a_s[3*FLD[i] +: 3] : b_s[3*(FLD[i]-8) +: 3];
         l = (c > 3'h4) ? 3'h5 : c;
         snk = (i < 10) && dir_s[i];
         if (continuous_mode && switch_closed[i] && c >= 3'h4 && !(snk ? b_s[22] : b_s[21]))
            l = 3'h2;
         r[3*i +: 3] = l;
      end
      return r;
   endfunction
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      u_host.wr(a, d);
      if (a == ADDR_DIR_SEL) dir_s = d & MASK_DIR_SEL;
      if (a == ADDR_WET_A) a_s = d & MASK_WET_A;
      if (a == ADDR_WET_B) b_s = d & MASK_WET_B;
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] d;
      logic              v;
      u_host.rd(a, d, v);
      chk({47'h0, v, d}, {48'h1, e});
   endtask
   task automatic lvchk();
      repeat (2) @(posedge sys_clk);
      #1;
      chk(wet_level, exp_lv());
      chk({60'h0, input_sink_sel, autoscale_off_sink, autoscale_off_source},
          {60'h0, dir_s[9:0], b_s[22], b_s[21]});
   endtask
   task automatic t_reset();
      lvchk();
      rchk(ADDR_DIR_SEL, 24'h00_0000);
      rchk(ADDR_WET_A, 24'h00_0000);
      rchk(ADDR_WET_B, 24'h00_0000);
   endtask
   task automatic t_dir();
      wr(ADDR_DIR_SEL, 24'hff_ffff);
      rchk(ADDR_DIR_SEL, 24'h00_03ff);
      lvchk();
      wr(ADDR_DIR_SEL, 24'h00_0155);
      rchk(ADDR_DIR_SEL, 24'h00_0155);
      lvchk();
   endtask
   // every code 0..7 lands in some field of the first register, codes 1..7 in the second
   task automatic t_wet();
      wr(ADDR_WET_A, 24'hfa_c688);
      rchk(ADDR_WET_A, 24'hfa_c688);
      lvchk();
      wr(ADDR_WET_B, 24'hff_ffff);
      rchk(ADDR_WET_B, 24'h7f_ffff);
      lvchk();
      wr(ADDR_WET_B, 24'h85_3977);
      rchk(ADDR_WET_B, 24'h05_3977);
      lvchk();
   endtask
   // input 0 sinks, its pair mate 1 sources, a few switches open
   task automatic t_scale();
      wr(ADDR_DIR_SEL, 24'h00_0001);
      wr(ADDR_WET_A, 24'h92_4924);
      wr(ADDR_WET_B, 24'h16_db6d);
      @(posedge sys_clk);
      continuous_mode <= 1'b1;
      switch_closed <= 24'hff_ff0f;
      lvchk();
      wr(ADDR_WET_B, 24'h36_db6d);
      lvchk();
      wr(ADDR_WET_B, 24'h56_db6d);
      lvchk();
      @(posedge sys_clk);
      continuous_mode <= 1'b0;
      lvchk();
   endtask
   task automatic t_unmapped();
      wr(6'h1f, 24'hff_ffff);
      wr(6'h00, 24'h12_3456);
      rchk(6'h1f, 24'h00_0000);
      rchk(6'h00, 24'h00_0000);
      rchk(ADDR_WET_A, a_s);
      lvchk();
   endtask
   // back-to-back write and read: readback must carry the new word, reserved bits dropped
   task automatic t_b2b();
      logic [DATA_W-1:0] d;
      logic              v;
      u_host.wr_rd(ADDR_WET_A, 24'h5a_3c96, d, v);
      a_s = 24'h5a_3c96;
      chk({47'h0, v, d}, {48'h1, a_s});
      u_host.wr_rd(ADDR_DIR_SEL, 24'ha5_5aaa, d, v);
      dir_s = 24'h00_02aa;
      chk({47'h0, v, d}, {48'h1, dir_s});
      lvchk();
   endtask
   task automatic t_midreset();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      dir_s = 24'h00_0000;
      a_s = 24'h00_0000;
      b_s = 24'h00_0000;
      t_reset();
   endtask
   task automatic finish_test();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_dir();
      t_wet();
      t_scale();
      t_unmapped();
      t_b2b();
      t_midreset();
      finish_test();
   end
   // whole run is under a hundred cycles
   initial begin
      #100us;
      fails++;
      finish_test();
   end
endmodule
